// File: cks_output_control_bank.sv
// Function
// - Byte command 100xxxxx; low bits pick offset
// - Byte0 bit6 sets bus clock strength
// - Byte0 bits1:0 report latched frequency straps
// - Byte1 bit7 makes reference clock stoppable
// - Byte1 bit6 enables reference pair, else tristate
// - Byte1 bits2:0 enable debug and CPU pairs
// - Byte2 bit7 tristates reference pair in powerdown
// - Byte2 bit6 tristates reference pair when halted
// - Byte2 bits5:3 tristate CPU pairs in powerdown
// - Clearing byte3 bit7 halts stoppable clocks cleanly
// - Setting it releases halt without runt pulses
// - Byte3/4 low bits enable bus clock outputs
// - Byte4 bits7:6 set 48MHz strength, enable
// - Byte4 bits5:3 make free clocks stoppable
`include "cks_defines.svh"
module cks_output_control_bank (
   input wire logic CLOCK, // 250 MHz clock
   input wire logic RST_N, // Async reset, active low
   input wire logic [7:0] CMD_CODE, // Serial command code
   input wire logic [7:0] WR_DATA, // Data byte from host
   input wire logic WR_STROBE, // One-cycle write pulse
   input wire logic RD_STROBE, // One-cycle read pulse
   input wire logic FREQ_STRAP_LOW, // Strap pin A
   input wire logic FREQ_STRAP_HIGH, // Strap pin B
   input wire logic POWER_DOWN, // Power-down in progress, high
   input wire logic BUS_CLK_EDGE, // Low phase of bus clocks
   input wire logic SRC_CLK_EDGE, // Low phase of reference clock
   output logic [7:0] RD_DATA, // Registered read byte
   output logic RD_VALID, // Read data valid pulse
   output cks_pkg::cks_out_t CLK_CTRL // Output control bundle
);
   localparam int NUM_BYTES = 5;
   localparam int NUM_PCI = 6;
   localparam int NUM_FREE = 3;
   localparam int NUM_CPU = 3;
   localparam logic [7:0] RESET_BYTES [0:4] = '{
      `CKS_RST_DRIVE,
      `CKS_RST_CPU_SRC,
      `CKS_RST_PWRDN,
      `CKS_RST_STOP_EN,
      `CKS_RST_FREE_48M
   };

   // Configuration bytes, indexed by the low bits of the offset
   logic [7:0] bank [0:4];
   logic [1:0] strap;
   logic strap_taken;
   logic [2:0] sel;
   logic halt_req;
   logic src_stoppable;
   logic bus_halted;
   logic src_halted;
   logic [7:0] next_rd_data;
   logic [5:0] next_pci_run;
   logic [2:0] next_free_run;
   logic [2:0] next_cpu_drive;
   logic next_src_drive;
   cks_pkg::cks_req_t req;

   // Accepts only byte commands that name one of the five bytes held here
   function automatic logic byte_hit(input logic [7:0] code);
      byte_hit = (code[7:5] == `CKS_BYTE_CMD_PREFIX) && (code[6:0] <= `CKS_OFS_FREE_48M);
   endfunction : byte_hit

   // An output stays on while enabled, unless a state it is set to obey is active
   function automatic logic kept_on(input logic enable, input logic in_state,
      input logic obeys_state);
      kept_on = enable && !(in_state && obeys_state);
   endfunction : kept_on

   assign req.offset = CMD_CODE[6:0];
   assign req.wdata = WR_DATA;
   assign req.write = WR_STROBE && byte_hit(CMD_CODE);
   assign req.read = RD_STROBE && byte_hit(CMD_CODE);
   // Offsets above four never pass byte_hit, so three bits index the bank
   assign sel = req.offset[2:0];

   // Straps are only valid at power-up, so take them on the first clock after reset
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         strap <= 2'h0;
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         strap <= {FREQ_STRAP_HIGH, FREQ_STRAP_LOW};
         strap_taken <= 1'b1;
      end
   end

   // Reserved bits are stored as written; the host keeps them at power-up values
   genvar b;
   generate
      for (b = 0; b < NUM_BYTES; b = b + 1) begin : g_byte
         always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
               bank[b] <= RESET_BYTES[b];
            end else if (req.write && sel == 3'(b)) begin
               bank[b] <= req.wdata;
            end
         end
      end
   endgenerate

   // Byte 0 shows the latched straps in its low bits, so writes never reach them
   always_comb begin
      next_rd_data = 8'h00;
      if (req.read) begin
         next_rd_data = bank[sel];
         if (req.offset == `CKS_OFS_DRIVE) begin
            next_rd_data[1:0] = strap;
         end
      end
   end

   // Refused reads still answer, with a zero byte
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= RD_STROBE;
      end
   end

   // Read byte stands until the next read strobe
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         RD_DATA <= 8'h00;
      end else if (RD_STROBE) begin
         RD_DATA <= next_rd_data;
      end
   end

   assign halt_req = !bank[3][`CKS_B3_HALT_N];
   assign src_stoppable = bank[1][`CKS_B1_SRC_STOPPABLE];

   // Halt and release only change during a low phase so no pulse is shortened
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         bus_halted <= 1'b0;
      end else if (BUS_CLK_EDGE) begin
         bus_halted <= halt_req;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         src_halted <= 1'b0;
      end else if (SRC_CLK_EDGE) begin
         src_halted <= halt_req && src_stoppable;
      end
   end

   genvar p;
   generate
      // Plain bus clocks have no stoppable bit: every one of them obeys a halt
      for (p = 0; p < NUM_PCI; p = p + 1) begin : g_pci
         assign next_pci_run[p] = kept_on(bank[3][p], bus_halted, 1'b1);
      end
      for (p = 0; p < NUM_FREE; p = p + 1) begin : g_free
         assign next_free_run[p] = kept_on(bank[4][p], bus_halted, bank[4][`CKS_B4_FREE_STOP_LSB + p]);
      end
      for (p = 0; p < NUM_CPU; p = p + 1) begin : g_cpu
         assign next_cpu_drive[p] = kept_on(bank[1][p], POWER_DOWN, bank[2][`CKS_B2_CPU_PD_LSB + p]);
      end
   endgenerate

   // The reference pair obeys two states: power-down and the software halt
   assign next_src_drive = kept_on(
      kept_on(bank[1][`CKS_B1_SRC_EN], POWER_DOWN, bank[2][`CKS_B2_SRC_PD_TRI]),
      src_halted, bank[2][`CKS_B2_SRC_STOP_TRI]);

   // Strength bits only steer pad drivers, no glitch care needed
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         CLK_CTRL.pci_strong <= 1'b0;
         CLK_CTRL.usb48_strong <= 1'b0;
      end else begin
         CLK_CTRL.pci_strong <= bank[0][`CKS_B0_PCI_STRONG];
         CLK_CTRL.usb48_strong <= bank[4][`CKS_B4_48M_STRONG];
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         CLK_CTRL.usb48_en <= 1'b0;
      end else begin
         CLK_CTRL.usb48_en <= bank[4][`CKS_B4_48M_EN];
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         CLK_CTRL.pci_run <= 6'h00;
      end else begin
         CLK_CTRL.pci_run <= next_pci_run;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         CLK_CTRL.free_run <= 3'h0;
      end else begin
         CLK_CTRL.free_run <= next_free_run;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         CLK_CTRL.src_drive <= 1'b0;
      end else begin
         CLK_CTRL.src_drive <= next_src_drive;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         CLK_CTRL.cpu_drive <= 3'h0;
      end else begin
         CLK_CTRL.cpu_drive <= next_cpu_drive;
      end
   end
endmodule : cks_output_control_bank

// File: cks_defines.svh
`ifndef CKS_DEFINES_SVH
`define CKS_DEFINES_SVH
`define CKS_BYTE_CMD_PREFIX 3'h4
`define CKS_OFS_DRIVE 7'h00
`define CKS_OFS_CPU_SRC 7'h01
`define CKS_OFS_PWRDN 7'h02
`define CKS_OFS_STOP_EN 7'h03
`define CKS_OFS_FREE_48M 7'h04
`define CKS_RST_DRIVE 8'h4C
`define CKS_RST_CPU_SRC 8'h7F
`define CKS_RST_PWRDN 8'h00
`define CKS_RST_STOP_EN 8'hFF
`define CKS_RST_FREE_48M 8'h47
`define CKS_B0_PCI_STRONG 6
`define CKS_B1_SRC_STOPPABLE 7
`define CKS_B1_SRC_EN 6
`define CKS_B2_SRC_PD_TRI 7
`define CKS_B2_SRC_STOP_TRI 6
`define CKS_B3_HALT_N 7
`define CKS_B4_48M_STRONG 7
`define CKS_B4_48M_EN 6
`define CKS_B2_CPU_PD_LSB 3
`define CKS_B4_FREE_STOP_LSB 3
`endif

// File: cks_pkg.sv
package cks_pkg;
   typedef struct packed {
      logic [6:0] offset;
      logic [7:0] wdata;
      logic write;
      logic read;
   } cks_req_t;
   typedef struct packed {
      logic pci_strong;
      logic usb48_strong;
      logic usb48_en;
      logic [5:0] pci_run;
      logic [2:0] free_run;
      logic src_drive;
      logic [2:0] cpu_drive;
   } cks_out_t;
endpackage : cks_pkg

// File: cks_bank_checker.sv
module cks_bank_checker (
   input wire logic CLOCK, // Clock
   input wire logic RST_N, // Reset
   input wire logic [7:0] CMD_CODE, // Command
   input wire logic [7:0] WR_DATA, // Write byte
   input wire logic WR_STROBE, // Write
   input wire logic RD_STROBE, // Read
   input wire logic FREQ_STRAP_LOW, // Strap
   input wire logic FREQ_STRAP_HIGH, // Strap
   input wire logic [7:0] RD_DATA, // Read byte
   input wire logic RD_VALID, // Valid
   input wire cks_pkg::cks_out_t CLK_CTRL // Controls
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   wire w0 = WR_STROBE && CMD_CODE == 8'h80;
   wire w4 = WR_STROBE && CMD_CODE == 8'h84;
   a_rd_valid_rise: assert property (RD_STROBE |=> RD_VALID) else $error("no valid");
   a_rd_valid_one: assert property (!RD_STROBE |=> !RD_VALID) else $error("extra valid");
   a_strap_report: assert property (RD_STROBE && CMD_CODE == 8'h80 |=>
      RD_DATA[1:0] == {FREQ_STRAP_HIGH, FREQ_STRAP_LOW}) else $error("strap");
   a_unmapped_zero: assert property (RD_STROBE && CMD_CODE[6:0] > 7'h04 |=> RD_DATA == 8'h00)
      else $error("unmapped");
   a_usb_enable: assert property (w4 |-> ##2 CLK_CTRL.usb48_en == $past(WR_DATA[6], 2))
      else $error("usb en");
   a_usb_strength: assert property (w4 |-> ##2 CLK_CTRL.usb48_strong == $past(WR_DATA[7], 2))
      else $error("usb drive");
   a_pci_strength: assert property (w0 |-> ##2 CLK_CTRL.pci_strong == $past(WR_DATA[6], 2))
      else $error("pci drive");
   a_data_stands: assert property (!RD_STROBE |=> $stable(RD_DATA)) else $error("data moved");
   c_write_usb: cover property (w4);
   c_write_pci: cover property (w0);
   c_read_bad: cover property (RD_STROBE && CMD_CODE[6:0] > 7'h04);
endmodule : cks_bank_checker
bind cks_output_control_bank cks_bank_checker u_chk (.CLOCK, .RST_N, .CMD_CODE, .WR_DATA,
   .WR_STROBE, .RD_STROBE, .FREQ_STRAP_LOW, .FREQ_STRAP_HIGH, .RD_DATA, .RD_VALID, .CLK_CTRL);

// File: cks_host_model.sv
module cks_host_model (
   input wire logic clk, // Bench clock
   output logic [7:0] cmd, // Command code
   output logic [7:0] wdat, // Write byte
   output logic wr, // Write pulse
   output logic rd // Read pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cmd, wdat, wr, rd} = 18'h00000;
   // Released command and data lines invert and both strobes drop to zero, so a stale byte never looks like a fresh one
   task automatic xfer(input logic w, input logic [6:0] ofs, input logic [7:0] d);
      @(negedge clk);
      {cmd, wdat, wr, rd} = {1'b1, ofs, d, w, !w};
      @(negedge clk);
      {cmd, wdat, wr, rd} = {~cmd, ~wdat, 2'b00};
   endtask : xfer
endmodule : cks_host_model

// File: clock_synth_output_control_bank_bench.sv
module clock_synth_output_control_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 0, RST_N = 0, pd = 0, edg = 1, wr, rd, rv;
   logic [7:0] cmd, wd, rdat, d;
   logic [1:0] fs = 2'h1;
   logic [31:0] s = 98367;
   logic [7:0] m [5] = '{8'h4C, 8'h7F, 8'h00, 8'hFF, 8'h47};
   logic [7:0] rm [5] = '{8'hBC, 8'h38, 8'h07, 8'h40, 8'h00};
   cks_pkg::cks_out_t ctl;
   int err_total = 0, checks = 0, o;
   always #2 CLOCK = ~CLOCK;
   cks_host_model u_host (.clk(CLOCK), .cmd(cmd), .wdat(wd), .wr(wr), .rd(rd));
   cks_output_control_bank u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .CMD_CODE(cmd), .WR_DATA(wd),
      .WR_STROBE(wr), .RD_STROBE(rd), .FREQ_STRAP_LOW(fs[0]), .FREQ_STRAP_HIGH(fs[1]),
      .POWER_DOWN(pd), .BUS_CLK_EDGE(edg), .SRC_CLK_EDGE(edg), .RD_DATA(rdat), .RD_VALID(rv),
      .CLK_CTRL(ctl));
   function automatic logic [7:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s[7:0];
   endfunction : rnd
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      checks++;
      if (g !== x) begin
         err_total++;
         $display("unexpected %s exp %h got %h", n, x, g);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic ctl_chk(input logic h);
      chk("ctl", {m[0][6], m[4][7:6], m[3][5:0] & {6{!h}}, m[4][2:0] & ~(m[4][5:3] & {3{h}}),
         m[1][6] & !(pd & m[2][7]) & !(h & m[1][7] & m[2][6]), m[1][2:0] & ~(m[2][5:3] & {3{pd}})},
         ctl);
   endtask : ctl_chk
   initial begin
      repeat (5) @(negedge CLOCK);
      RST_N = 1;
      repeat (2) @(negedge CLOCK);
      ctl_chk(0);
      for (int i = 0; i < 60; i++) begin
         o = rnd() % 5;
         pd = rnd() > 8'hB0;
         // Top bit of byte 3 kept set so random traffic never halts the clocks
         d = (rnd() & ~rm[o]) | (m[o] & rm[o]) | ((o == 3) ? 8'h80 : 8'h00);
         u_host.xfer(1, o[6:0], d);
         m[o] = d;
         u_host.xfer(0, o[6:0], 8'h00);
         chk("rd", {8'h01, (o == 0) ? {m[0][7:2], fs} : m[o]}, {7'h00, rv, rdat});
         ctl_chk(0);
      end
      $display("random traffic done");
      u_host.xfer(0, 7'h05, 8'h00);
      chk("unmapped", 16'h0100, {7'h00, rv, rdat});
      edg = 0;
      d = m[3] & 8'h7F;
      u_host.xfer(1, 7'h03, d);
      m[3] = d;
      repeat (3) @(negedge CLOCK);
      ctl_chk(0);
      edg = 1;
      repeat (3) @(negedge CLOCK);
      ctl_chk(1);
      u_host.xfer(1, 7'h03, d | 8'h80);
      m[3] = d | 8'h80;
      repeat (3) @(negedge CLOCK);
      ctl_chk(0);
      $display("halt and resume done");
      // Second reset with new strap levels: straps must be relatched, bytes restored
      RST_N = 0;
      fs = 2'(rnd());
      m = '{8'h4C, 8'h7F, 8'h00, 8'hFF, 8'h47};
      repeat (2) @(negedge CLOCK);
      RST_N = 1;
      repeat (2) @(negedge CLOCK);
      ctl_chk(0);
      u_host.xfer(0, 7'h00, 8'h00);
      chk("strap", {8'h01, m[0][7:2], fs}, {7'h00, rv, rdat});
      $display("reset with new straps done");
      stop_test();
   end
   initial begin
      #5000;
      err_total++;
      stop_test();
   end
endmodule : clock_synth_output_control_bank_bench
